// >>> rtl/sst_defs.svh
// constants of the security supervisor: timing counts, widths, status bits
// assumes one 25 MHz system clock
`ifndef SST_DEFS_SVH
`define SST_DEFS_SVH
`define SST_CLK_MHZ 25
`define SST_CRC_POLY 32'h04C11DB7
`define SST_CRC_INIT 32'hFFFFFFFF
`define SST_STAT_ERROR 0
`define SST_STAT_APPROVED 1
`define SST_STAT_DONE 2
`define SST_STAT_BUSY 3
`define SST_STAT_SECRETS 4
`define SST_STAT_AUTH 5
`define SST_STAT_WIDTH 8
`define SST_FAIL_KAT 0
`define SST_FAIL_FWCRC 1
`define SST_FAIL_RNG 2
`define SST_FAIL_CSPCRC 3
`define SST_IRQ_US 1
`define SST_IRQ_CYCLES ((`SST_IRQ_US * `SST_CLK_MHZ) < 1 ? 1 : (`SST_IRQ_US * `SST_CLK_MHZ))
`endif

// >>> rtl/sst_pkg.sv
// types of the security supervisor
// assumes sst_defs.svh is on the include path
package sst_pkg;
   typedef enum logic [9:0]
   {
      SST_KAT_ENC = 10'h001,
      SST_KAT_DEC = 10'h002,
      SST_KAT_DRBG = 10'h004,
      SST_KAT_SHA = 10'h008,
      SST_FW_CRC = 10'h010,
      SST_FW_CHK = 10'h020,
      SST_IDLE = 10'h040,
      SST_CFG_ID = 10'h080,
      SST_CFG_SEED = 10'h100,
      SST_ERROR = 10'h200
   } sst_state_t;
endpackage

// >>> rtl/sst_crc32.sv
// bytewise crc-32 accumulator, one byte per clock
// assumes the caller clears it before a new image
module sst_crc32
   import sst_pkg::*;
(
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic clear,
   input wire logic byteValid,
   input wire logic [7:0] byteData,
   output logic [31:0] crc
);
`include "sst_defs.svh"
   logic [31:0] crc_reg;
   logic [31:0] crc_next;
   logic [31:0] stage [0:8];

   // eight serial steps of the polynomial division
   assign stage[0] = crc_reg;
   genvar i;
   generate
      for (i = 0; i < 8; i++)
      begin : g_bit
         wire fb = stage[i][31] ^ byteData[7 - i];
         assign stage[i + 1] = {stage[i][30:0], 1'b0} ^ (fb ? `SST_CRC_POLY : 32'h00000000);
      end
   endgenerate
   assign crc_next = clear ? `SST_CRC_INIT : (byteValid ? stage[8] : crc_reg);
   assign crc = crc_reg;

   // accumulator register
   always_ff @(posedge sys_clk)
   begin
      if (rst)
         crc_reg <= `SST_CRC_INIT;
      else
         crc_reg <= crc_next;
   end
endmodule

// >>> rtl/sst_supervisor.sv
// security supervisor: power-up self-test sequence, conditional tests,
// latched error state, approved/non-approved mode and secret zeroization
// assumes engines (aes, sha, drbg) report results by one-cycle pulses and that
// flash images stream in one byte per clock; one clock, synchronous reset
// Functional notes
// - power-up runs all known-answer and firmware tests
// - firmware check is 32-bit crc compare
// - power-up failure latches error, blocks storage
// - conditional failure latches same error, blocks storage
// - status output shows error state
// - reset re-runs the whole self-test sequence
// - repetition tests on generator and entropy first
// - crc check stored secrets before reading them
// - generator state rewritten after each generation
// - aes key volatile, other secrets in flash
// - challenge-response held only during authentication
// - no external read path to secrets
// - reset without secrets means non-approved mode
// - credential and identifier start unset
// - configure: write id, make seed, approve
// - status output shows approved or not
// - change-mode zeroizes all secrets, leaves approved
// - no storage path bypasses the crypto
// - self-test completion raises interrupt notification
module sst_supervisor
   import sst_pkg::*;
#(
   parameter int ID_BYTES = 30,
   parameter int CRED_BYTES = 4
)
(
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic katDone,
   input wire logic katPass,
   input wire logic fwByteValid,
   input wire logic [7:0] fwByte,
   input wire logic fwLast,
   input wire logic [31:0] fwExpectedCrc,
   input wire logic genRequest,
   input wire logic genRepeatFail,
   input wire logic entropyRepeatFail,
   input wire logic flashByteValid,
   input wire logic [7:0] flashByte,
   input wire logic flashLast,
   input wire logic [31:0] flashStoredCrc,
   input wire logic cmdConfigure,
   input wire logic cmdChangeMode,
   input wire logic cmdStatus,
   input wire logic flashWriteDone,
   input wire logic seedDone,
   input wire logic authActive,
   input wire logic secretsPresent,
   input wire logic cryptPathReady,
   output logic katStart,
   output logic [1:0] katSelect,
   output logic fwCrcActive,
   output logic genGrant,
   output logic genStateWrite,
   output logic flashReadAllow,
   output logic idWrite,
   output logic seedGenerate,
   output logic zeroize,
   output logic challengeKeep,
   output logic storageEnable,
   output logic irq,
   output logic statusValid,
   output logic [7:0] statusByte
);
`include "sst_defs.svh"
   sst_state_t state_reg, state_next;
   logic approved_reg, approved_next;
   logic testsDone_reg;
   logic [3:0] failCause_reg, failCause_next;
   logic katStart_reg, katStart_next;
   logic [1:0] katSel_reg;
   logic genGrant_reg, genWrite_reg, flashAllow_reg;
   logic idWrite_reg, seedGen_reg, zeroize_reg;
   logic challenge_reg, storage_reg;
   logic irq_reg;
   logic [7:0] irqCnt_reg;
   logic statusValid_reg;
   logic [7:0] status_reg;
   logic fwDone_reg;
   logic cspFail_reg, cspCheck_reg;
   logic [31:0] fwCrc;
   logic [31:0] cspCrc;
   logic startCount_reg;

   // two crc engines: firmware image and stored secrets
   wire fwClear = rst | (state_reg == SST_KAT_ENC);
   sst_crc32 u_fw_crc
   (
      .sys_clk(sys_clk),
      .rst(rst),
      .clear(fwClear),
      .byteValid(fwByteValid && (state_reg == SST_FW_CRC)),
      .byteData(fwByte),
      .crc(fwCrc)
   );
   wire cspClear = (state_reg != SST_IDLE) | cspCheck_reg;
   sst_crc32 u_csp_crc
   (
      .sys_clk(sys_clk),
      .rst(rst),
      .clear(cspClear),
      .byteValid(flashByteValid && (state_reg == SST_IDLE)),
      .byteData(flashByte),
      .crc(cspCrc)
   );

   // decode of events and test results
   wire katFail = katDone && !katPass;
   wire fwMismatch = fwDone_reg && (fwCrc != fwExpectedCrc);
   wire rngFail = genRequest && (genRepeatFail || entropyRepeatFail);
   wire cspStep = flashByteValid && flashLast && (state_reg == SST_IDLE);
   wire cspMismatch = cspFail_reg;
   wire condFail = rngFail || cspMismatch;
   wire inError = (state_reg == SST_ERROR);
   wire goodGen = genRequest && !genRepeatFail && !entropyRepeatFail && (state_reg == SST_IDLE);
   wire [7:0] statusNext = {2'b00, authActive, secretsPresent && approved_reg,
      !testsDone_reg && !inError, testsDone_reg, approved_reg, inError};

   // sequencer: kat steps, firmware crc, idle service, latched error
   always_comb
   begin
      state_next = state_reg;
      katStart_next = 1'b0;
      failCause_next = failCause_reg;
      approved_next = approved_reg;
      case (state_reg)
         SST_KAT_ENC, SST_KAT_DEC, SST_KAT_DRBG, SST_KAT_SHA:
         begin
            if (katFail)
            begin
               state_next = SST_ERROR;
               failCause_next[`SST_FAIL_KAT] = 1'b1;
            end
            else if (katDone)
            begin
               katStart_next = (state_reg != SST_KAT_SHA);
               case (state_reg)
                  SST_KAT_ENC: state_next = SST_KAT_DEC;
                  SST_KAT_DEC: state_next = SST_KAT_DRBG;
                  SST_KAT_DRBG: state_next = SST_KAT_SHA;
                  default: state_next = SST_FW_CRC;
               endcase
            end
         end
         SST_FW_CRC:
            if (fwByteValid && fwLast)
               state_next = SST_FW_CHK;
         SST_FW_CHK:
            if (fwDone_reg)
            begin
               if (fwMismatch)
               begin
                  state_next = SST_ERROR;
                  failCause_next[`SST_FAIL_FWCRC] = 1'b1;
               end
               else
                  state_next = SST_IDLE;
            end
         SST_IDLE:
         begin
            if (condFail)
            begin
               state_next = SST_ERROR;
               failCause_next[`SST_FAIL_RNG] = rngFail;
               failCause_next[`SST_FAIL_CSPCRC] = cspMismatch;
            end
            else if (cmdChangeMode)
               approved_next = 1'b0;
            else if (cmdConfigure)
               state_next = SST_CFG_ID;
         end
         SST_CFG_ID:
            if (flashWriteDone)
               state_next = SST_CFG_SEED;
         SST_CFG_SEED:
            if (seedDone)
            begin
               state_next = SST_IDLE;
               approved_next = 1'b1;
            end
         SST_ERROR:
            state_next = SST_ERROR;
         default:
            state_next = SST_ERROR;
      endcase
   end

   // state, mode and fault cause; reset restarts the tests
   always_ff @(posedge sys_clk)
   begin
      if (rst)
      begin
         state_reg <= SST_KAT_ENC;
         approved_reg <= 1'b0;
         failCause_reg <= 4'h0;
         katStart_reg <= 1'b0;
         startCount_reg <= 1'b1;
      end
      else
      begin
         state_reg <= state_next;
         approved_reg <= approved_next;
         failCause_reg <= failCause_next;
         katStart_reg <= katStart_next | startCount_reg;
         startCount_reg <= 1'b0;
      end
   end

   // kat selector and test completion tracking
   always_ff @(posedge sys_clk)
   begin
      if (rst)
      begin
         katSel_reg <= 2'h0;
         testsDone_reg <= 1'b0;
         fwDone_reg <= 1'b0;
      end
      else
      begin
         if (katDone && katPass)
            katSel_reg <= katSel_reg + 2'h1;
         if ((state_reg == SST_FW_CHK) && fwDone_reg && !fwMismatch)
            testsDone_reg <= 1'b1;
         fwDone_reg <= (state_reg == SST_FW_CRC) && fwByteValid && fwLast;
      end
   end

   // secret crc verdict taken one cycle after the last byte
   always_ff @(posedge sys_clk)
   begin
      if (rst)
      begin
         cspCheck_reg <= 1'b0;
         cspFail_reg <= 1'b0;
      end
      else
      begin
         cspCheck_reg <= cspStep;
         cspFail_reg <= cspCheck_reg && (cspCrc != flashStoredCrc);
      end
   end

   // generator grant, state write-back, flash read permit
   always_ff @(posedge sys_clk)
   begin
      if (rst)
      begin
         genGrant_reg <= 1'b0;
         genWrite_reg <= 1'b0;
         flashAllow_reg <= 1'b0;
      end
      else
      begin
         genGrant_reg <= goodGen;
         genWrite_reg <= genGrant_reg && !inError;
         flashAllow_reg <= cspCheck_reg && (cspCrc == flashStoredCrc) && !condFail;
      end
   end

   // configure and zeroize strobes, challenge hold, storage gate
   always_ff @(posedge sys_clk)
   begin
      if (rst)
      begin
         idWrite_reg <= 1'b0;
         seedGen_reg <= 1'b0;
         zeroize_reg <= 1'b1;
         challenge_reg <= 1'b0;
         storage_reg <= 1'b0;
      end
      else
      begin
         idWrite_reg <= (state_next == SST_CFG_ID) && (state_reg == SST_IDLE);
         seedGen_reg <= (state_next == SST_CFG_SEED) && (state_reg == SST_CFG_ID);
         zeroize_reg <= (state_reg == SST_IDLE) && cmdChangeMode && !condFail;
         challenge_reg <= authActive && approved_reg && !inError;
         storage_reg <= testsDone_reg && (state_next != SST_ERROR) && cryptPathReady;
      end
   end

   // completion interrupt: pulse stretched to a fixed width
   always_ff @(posedge sys_clk)
   begin
      if (rst)
      begin
         irq_reg <= 1'b0;
         irqCnt_reg <= 8'h00;
      end
      else if (((state_reg == SST_FW_CHK) && fwDone_reg) || (state_next == SST_ERROR
         && state_reg != SST_ERROR && state_reg != SST_IDLE))
      begin
         irq_reg <= 1'b1;
         irqCnt_reg <= 8'(`SST_IRQ_CYCLES - 1);
      end
      else if (irqCnt_reg != 8'h00)
         irqCnt_reg <= irqCnt_reg - 8'h01;
      else
         irq_reg <= 1'b0;
   end

   // status answer: flags only, never secret contents
   always_ff @(posedge sys_clk)
   begin
      if (rst)
      begin
         statusValid_reg <= 1'b0;
         status_reg <= 8'h00;
      end
      else
      begin
         statusValid_reg <= cmdStatus;
         status_reg <= cmdStatus ? statusNext : status_reg;
      end
   end

   assign katStart = katStart_reg;
   assign katSelect = katSel_reg;
   assign fwCrcActive = (state_reg == SST_FW_CRC) ? 1'b1 : 1'b0;
   assign genGrant = genGrant_reg;
   assign genStateWrite = genWrite_reg;
   assign flashReadAllow = flashAllow_reg;
   assign idWrite = idWrite_reg;
   assign seedGenerate = seedGen_reg;
   assign zeroize = zeroize_reg;
   assign challengeKeep = challenge_reg;
   assign storageEnable = storage_reg;
   assign irq = irq_reg;
   assign statusValid = statusValid_reg;
   assign statusByte = status_reg;
endmodule

// >>> test/sst_supervisor_monitor.sv
// port assertions of the security supervisor
// assumes the bind below attaches it
module sst_supervisor_monitor
(
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic genRequest,
   input wire logic genRepeatFail,
   input wire logic entropyRepeatFail,
   input wire logic flashLast,
   input wire logic flashWriteDone,
   input wire logic cmdStatus,
   input wire logic cryptPathReady,
   input wire logic genGrant,
   input wire logic genStateWrite,
   input wire logic flashReadAllow,
   input wire logic seedGenerate,
   input wire logic storageEnable,
   input wire logic irq,
   input wire logic statusValid,
   input wire logic [7:0] statusByte
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] irqCnt_reg;
   default clocking @(posedge sys_clk);
   endclocking
   default disable iff (rst);
   // cycles the notification has stood so far
   always_ff @(posedge sys_clk)
      irqCnt_reg <= (rst || !irq) ? 8'h00 : irqCnt_reg + 8'h01;
   grant_clean_a: assert property (
      genGrant |-> $past(genRequest && !genRepeatFail && !entropyRepeatFail))
      else $error("grant without clean request");
   state_write_a: assert property (genStateWrite |-> $past(genGrant))
      else $error("state write without grant");
   flash_read_a: assert property (
      flashReadAllow |-> $past(flashLast) || $past(flashLast, 2))
      else $error("secret read without check");
   storage_gate_a: assert property (
      storageEnable |-> cryptPathReady || $past(cryptPathReady))
      else $error("storage open without crypto path");
   status_reply_a: assert property (statusValid |-> $past(cmdStatus))
      else $error("status without command");
   error_block_a: assert property (
      statusValid && statusByte[0] |-> !storageEnable)
      else $error("storage open in error");
   irq_length_a: assert property ($fell(irq) |-> irqCnt_reg == 8'h19)
      else $error("notification length wrong");
   seed_order_a: assert property (
      seedGenerate |-> $past(flashWriteDone) || $past(flashWriteDone, 2))
      else $error("seed before id write");
endmodule
bind sst_supervisor sst_supervisor_monitor i_mon (.sys_clk, .rst, .genRequest,
   .genRepeatFail, .entropyRepeatFail, .flashLast, .flashWriteDone, .cmdStatus,
   .cryptPathReady, .genGrant, .genStateWrite, .flashReadAllow, .seedGenerate,
   .storageEnable, .irq, .statusValid, .statusByte);

// >>> test/sst_host_model.sv
// engines and firmware store beside the supervisor
// assumes the bench raises katBad or fwBad to inject faults
module sst_host_model
(
   input wire logic sys_clk,
   input wire logic katStart,
   input wire logic fwCrcActive,
   input wire logic idWrite,
   input wire logic seedGenerate,
   input wire logic katBad,
   input wire logic fwBad,
   output logic katDone,
   output logic katPass,
   output logic fwByteValid,
   output logic [7:0] fwByte,
   output logic fwLast,
   output logic [31:0] fwExpectedCrc,
   output logic flashWriteDone,
   output logic seedDone
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [2:0] fwCnt_reg;
   logic [1:0] katDly_reg, idDly_reg, seedDly_reg;
   // crc of an n byte image, msb first, no final inversion
   function automatic logic [31:0] crcOf(input int n);
      logic [31:0] c;
      logic [7:0] d;
      c = 32'hFFFFFFFF;
      for (int i = 0; i < n; i++)
      begin
         d = 8'hA5 ^ 8'(i);
         for (int b = 7; b >= 0; b--)
            c = {c[30:0], 1'h0} ^ ((c[31] ^ d[b]) ? 32'h04C11DB7 : 32'h00000000);
      end
      return c;
   endfunction
   // engines answer two cycles after a start
   always_ff @(posedge sys_clk)
   begin
      katDly_reg <= {katDly_reg[0], katStart};
      idDly_reg <= {idDly_reg[0], idWrite};
      seedDly_reg <= {seedDly_reg[0], seedGenerate};
      fwCnt_reg <= fwCrcActive ? fwCnt_reg + 3'(fwByteValid) : 3'h0;
   end
   assign katDone = katDly_reg[1];
   assign katPass = katDone ? !katBad : katDly_reg[0];
   assign flashWriteDone = idDly_reg[1];
   assign seedDone = seedDly_reg[1];
   // four byte image; the data lines toggle when nothing is sent
   assign fwByteValid = fwCrcActive && fwCnt_reg < 3'h4;
   assign fwByte = 8'hA5 ^ {5'h00, fwCnt_reg} ^ {8{!fwByteValid}};
   assign fwLast = fwByteValid && fwCnt_reg == 3'h3;
   assign fwExpectedCrc = crcOf(4) ^ {31'h0, fwBad};
endmodule

// >>> test/security_selftest_mode_control_test.sv
// self-checking bench of the security supervisor
// assumes the host model answers engine starts and sends the firmware
module security_selftest_mode_control_test;
   timeunit 1ns;
   timeprecision 1ps;
   logic sys_clk = 0, rst = 1, katBad = 0, fwBad = 0;
   logic genRequest = 0, genRepeatFail = 0, entropyRepeatFail = 0;
   logic flashByteValid = 0, flashLast = 0, cmdConfigure = 0, cmdChangeMode = 0;
   logic cmdStatus = 0, authActive = 0, secretsPresent = 0, cryptPathReady = 1;
   logic [7:0] flashByte = 8'h00;
   logic [31:0] flashStoredCrc = 32'h00000000;
   logic katDone, katPass, fwByteValid, fwLast, flashWriteDone, seedDone;
   logic katStart, fwCrcActive, genGrant, genStateWrite, flashReadAllow, idWrite;
   logic seedGenerate, zeroize, challengeKeep, storageEnable, irq, statusValid;
   logic [1:0] katSelect;
   logic [7:0] fwByte, statusByte;
   logic [31:0] fwExpectedCrc;
   int error_cnt = 0, compares = 0;
   always #20 sys_clk = ~sys_clk;
   sst_supervisor i_dut (.sys_clk, .rst, .katDone, .katPass, .fwByteValid, .fwByte, .fwLast,
      .fwExpectedCrc, .genRequest, .genRepeatFail, .entropyRepeatFail, .flashByteValid,
      .flashByte, .flashLast, .flashStoredCrc, .cmdConfigure, .cmdChangeMode, .cmdStatus,
      .flashWriteDone, .seedDone, .authActive, .secretsPresent, .cryptPathReady, .katStart,
      .katSelect, .fwCrcActive, .genGrant, .genStateWrite, .flashReadAllow, .idWrite,
      .seedGenerate, .zeroize, .challengeKeep, .storageEnable, .irq, .statusValid, .statusByte);
   sst_host_model i_host (.sys_clk, .katStart, .fwCrcActive, .idWrite, .seedGenerate, .katBad,
      .fwBad, .katDone, .katPass, .fwByteValid, .fwByte, .fwLast, .fwExpectedCrc,
      .flashWriteDone, .seedDone);
   // helpers: step past an edge, compare, bounded wait outcome
   task automatic tick(input int n = 1);
      repeat (n) @(posedge sys_clk);
      #1;
   endtask
   task automatic check(input logic [7:0] got, input logic [7:0] exp);
      compares++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("BAD %0t got %h want %h", $time, got, exp);
      end
   endtask
   task automatic must(input logic got);
      check({7'h00, got}, 8'h01);
      if (got !== 1'h1)
         end_of_test();
   endtask
   task automatic status(input logic [7:0] mask, input logic [7:0] exp);
      cmdStatus = 1;
      tick();
      cmdStatus = 0;
      for (int i = 0; i < 9 && !statusValid; i++) tick();
      must(statusValid);
      check(statusByte & mask, exp);
   endtask
   task automatic doReset(input int expStarts = 4);
      int starts = 0;
      rst = 1;
      tick(4);
      check(zeroize, 8'h01);
      rst = 0;
      for (int i = 0; i < 200 && !irq; i++)
      begin
         if (katStart)
         begin
            check(katSelect, 8'(starts));
            starts++;
         end
         tick();
      end
      must(irq);
      check(8'(starts), 8'(expStarts));
      tick(3);
   endtask
   // clean power-up: done, non-approved, storage follows the crypto path
   task automatic powerUp();
      doReset();
      status(8'h1F, 8'h04);
      check(storageEnable, 8'h01);
      cryptPathReady = 0;
      tick(2);
      check(storageEnable, 8'h00);
      cryptPathReady = 1;
      tick(2);
   endtask
   // generator use is granted, then its state rewritten
   task automatic genUse();
      genRequest = 1;
      tick();
      genRequest = 0;
      for (int i = 0; i < 4 && !genGrant; i++) tick();
      must(genGrant);
      for (int i = 0; i < 4 && !genStateWrite; i++) tick();
      must(genStateWrite);
   endtask
   // configure walks id write, seed, approval; change mode zeroizes
   task automatic cfgAndClear();
      secretsPresent = 1;
      // one command carries the credential and the identifier together
      cmdConfigure = 1;
      tick();
      cmdConfigure = 0;
      for (int i = 0; i < 9 && !idWrite; i++) tick();
      must(idWrite);
      for (int i = 0; i < 9 && !seedGenerate; i++) tick();
      must(seedGenerate);
      tick(6);
      status(8'h1F, 8'h16);
      authActive = 1;
      tick(2);
      check(challengeKeep, 8'h01);
      authActive = 0;
      tick(2);
      check(challengeKeep, 8'h00);
      cmdChangeMode = 1;
      tick();
      cmdChangeMode = 0;
      for (int i = 0; i < 9 && !zeroize; i++) tick();
      must(zeroize);
      tick(2);
      status(8'h12, 8'h00);
      secretsPresent = 0;
   endtask
   // stored secrets are released only on a crc match
   task automatic flashRead(input logic good);
      flashStoredCrc = i_host.crcOf(2) ^ {31'h0, !good};
      for (int i = 0; i < 2; i++)
      begin
         flashByteValid = 1;
         flashByte = 8'hA5 ^ 8'(i);
         flashLast = i == 1;
         tick();
      end
      flashByteValid = 0;
      flashLast = 0;
      flashByte = ~flashByte;
      for (int i = 0; i < 4 && !flashReadAllow; i++) tick();
      check(flashReadAllow, {7'h00, good});
      status(8'h01, {7'h00, !good});
   endtask
   // a repetition fault latches the error until a passing reset
   task automatic repFail(input logic gen);
      genRepeatFail = gen;
      entropyRepeatFail = !gen;
      genRequest = 1;
      tick();
      genRequest = 0;
      tick(3);
      check(storageEnable, 8'h00);
      cmdConfigure = 1;
      tick();
      cmdConfigure = 0;
      tick(9);
      status(8'h03, 8'h01);
      doReset();
      status(8'h01, 8'h00);
   endtask
   // a failed start-up test latches the error
   task automatic startFail(input logic kat);
      katBad = kat;
      fwBad = !kat;
      doReset(kat ? 1 : 4);
      katBad = 0;
      fwBad = 0;
      check(storageEnable, 8'h00);
      status(8'h01, 8'h01);
   endtask
   task automatic end_of_test();
      $display("errors %0d compares %0d", error_cnt, compares);
      if (error_cnt == 0 && compares > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   // main sequence
   initial
   begin
      powerUp();
      genUse();
      cfgAndClear();
      flashRead(1);
      flashRead(0);
      powerUp();
      repFail(1);
      repFail(0);
      startFail(1);
      startFail(0);
      doReset();
      status(8'h01, 8'h00);
      end_of_test();
   end
endmodule
